// [rfm_fifo.sv]
`timescale 1ns/1ps
module rfm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_in, // Clock.
  input  wire logic             rst_in,      // Synchronous reset.
  input  wire logic [WIDTH-1:0] wr_data_in,  // Write word.
  input  wire logic             wr_valid_in, // Write request.
  output logic                  wr_ready_out,// Space available.
  output logic [WIDTH-1:0]      rd_data_out, // Oldest word.
  output logic                  rd_valid_out,// Word available.
  input  wire logic             rd_ready_in  // Consumer takes word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp, rp, next_wp, next_rp;
  logic [AW:0]      cnt, next_cnt;
  logic             push, pop;

  // Pointer and count update; full and empty follow the count honestly.
  always_comb begin
    push     = wr_valid_in && (cnt != AW'(0) + (AW+1)'(DEPTH));
    pop      = rd_ready_in && (cnt != '0);
    next_wp  = push ? wp + 1'b1 : wp;
    next_rp  = pop ? rp + 1'b1 : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
    if (push) mem[wp] <= wr_data_in;
  end

  assign wr_ready_out = (cnt != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt != '0);
  assign rd_data_out  = mem[rp];
endmodule : rfm_fifo

// [rfm_host.sv]
`timescale 1ns/1ps
// Host model: it reads one word in each chip-select frame.
module rfm_host (
  input  wire logic        core_clk_in,   // Clock.
  input  wire logic [15:0] shift_word_in, // Loaded response word.
  output logic             cs_n_out,      // Chip select, low.
  output logic             done_out,      // Command complete.
  output logic [8:0]       addr_out       // Read address.
);
  // The host stays idle until a read is called.
  initial begin
    cs_n_out = 1'b1;
    done_out = 1'b0;
    addr_out = 9'h1ff;
  end
  // The host selects, waits past the capture, completes, then takes the word.
  // The address goes to its inverse after deselect, so no stale value lingers.
  task automatic read_word(input logic [8:0] a, output logic [15:0] w);
    @(negedge core_clk_in);
    addr_out = a;
    cs_n_out = 1'b0;
    repeat (4) @(negedge core_clk_in);
    done_out = 1'b1;
    repeat (4) @(negedge core_clk_in);
    w = shift_word_in;
    cs_n_out = 1'b1;
    done_out = 1'b0;
    addr_out = ~a;
  endtask : read_word
endmodule : rfm_host

// [rfm_monitor.sv]
`timescale 1ns/1ps
module rfm_monitor
  import rfm_pkg::*;
(
  input  wire logic                core_clk_in,   // 25 MHz clock.
  input  wire logic                rst_in,        // Synchronous reset.
  input  wire logic                sample_tick_in,// Resonator sample pulse.
  input  wire logic signed [15:0]  demod_in,      // Demodulated sample.
  input  wire logic signed [15:0]  cal_offset_in, // Calibration offset.
  input  wire logic        [15:0]  cal_gain_in,   // Gain, 1.0 = 0x1000.
  input  wire logic signed [15:0]  cal_st_in,     // Self-test correction.
  input  wire logic                cs_n_in,       // Chip select, low.
  input  wire logic                cmd_done_in,   // Command complete.
  input  wire logic        [8:0]   cmd_addr_in,   // Read address.
  output logic                     st_drive_out,  // Stimulus polarity.
  output logic signed [15:0]       rate_out,      // Rate register.
  output logic        [15:0]       self_test_memory_out, // Reg 0x04.
  output logic                     self_test_fault_flag_out, // Fault.
  output logic        [1:0]        sensor_status_field_out, // Status.
  output logic        [15:0]       shift_word_out // Loaded response.
);
  // Calibrated sample and crossings; chip select and done synchronised through two flops.
  logic [1:0] cs_sync, done_sync;
  logic signed [15:0] cal_sample;
  logic signed [ACC_W-1:0] sum1, sum2, next_sum1, next_sum2;
  logic signed [15:0] hist1 [TAPS];
  logic signed [ACC_W-1:0] hist2 [TAPS];
  logic [5:0] hidx;
  logic [3:0] st_cnt;
  logic signed [ACC_W-1:0] st_acc, st_y, next_st_y, st_part;
  logic signed [31:0] gprod;
  logic [15:0] st_mag, dev, held, capture;
  logic fifo_rdy, fifo_val;
  logic [15:0] fifo_q;
  logic cs_prev, done_prev;

  // Offset and gain correction of the incoming sample.
  always_comb begin
    gprod      = 32'(demod_in - cal_offset_in) * $signed({1'b0, cal_gain_in});
    cal_sample = gprod[27:12];
  end

  // Two running sums; each subtracts the sample 64 steps old.
  always_comb begin
    next_sum1 = sum1 + ACC_W'(cal_sample) - ACC_W'(hist1[hidx]);
    next_sum2 = sum2 + next_sum1 - hist2[hidx];
  end

  always_ff @(posedge core_clk_in) begin
    cs_sync   <= {cs_sync[0], cs_n_in};
    done_sync <= {done_sync[0], cmd_done_in};
    if (rst_in) begin
      sum1 <= '0; sum2 <= '0; hidx <= '0; rate_out <= '0;
      st_cnt <= '0; st_acc <= '0; st_y <= '0; st_drive_out <= 1'b0;
      for (int i = 0; i < TAPS; i++) begin
        hist1[i] <= '0;
        hist2[i] <= '0;
      end
    end else if (sample_tick_in) begin
      sum1 <= next_sum1;
      sum2 <= next_sum2;
      hist1[hidx] <= cal_sample;
      hist2[hidx] <= next_sum1;
      hidx <= hidx + 6'h01;
      rate_out <= 16'(next_sum2 >>> 12);
      // Polarity flips each sample so the stimulus cancels in the sums.
      st_drive_out <= ~st_drive_out;
      // Demodulate the shared-chain sample by the stimulus sign.
      st_acc <= st_part;
      st_cnt <= st_cnt + 4'h1;
      if (st_cnt == 4'(ST_DIV - 1)) st_y <= next_st_y;
    end
  end

  always_comb begin
    st_part   = (st_cnt == 4'h0 ? '0 : st_acc) +
                (st_drive_out ? ACC_W'(cal_sample) : -ACC_W'(cal_sample));
    // y = (63*y + x) / 64 gives 1/(64 - 63 z^-1) with unity DC gain.
    // The group sum holds ST_DIV half-differences; scaling it by ST_DIV/2
    // leaves the plain positive-minus-negative difference amplitude.
    next_st_y = ACC_W'((ST_FEEDBACK * st_y
                        + (st_part >>> ($clog2(ST_DIV) - 1))
                        + ACC_W'(cal_st_in)) / ST_GAIN);
    st_mag    = st_y[15:0];
    dev       = (st_mag > ST_NOMINAL) ? st_mag - ST_NOMINAL
                                      : ST_NOMINAL - st_mag;
  end

  // Continuous comparison against the two fixed tolerances.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      self_test_fault_flag_out <= 1'b0;
      sensor_status_field_out  <= STATUS_VALID;
      self_test_memory_out     <= '0;
    end else begin
      self_test_memory_out     <= st_mag;
      self_test_fault_flag_out <= (dev > ST_MILD_TOL);
      sensor_status_field_out  <= (dev > ST_SEVERE_TOL) ? STATUS_INVALID
                                                       : STATUS_VALID;
    end
  end

  // Capture at chip select fall, load shifter when command completes.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cs_prev <= 1'b1; done_prev <= 1'b0; held <= '0; shift_word_out <= '0;
    end else begin
      cs_prev   <= cs_sync[1];
      done_prev <= done_sync[1];
      if (cs_prev && !cs_sync[1]) held <= capture;
      if (!done_prev && done_sync[1]) shift_word_out <= held;
    end
  end

  always_comb begin
    capture = (cmd_addr_in == ADDR_SELF_TEST) ? self_test_memory_out
            : (fifo_val ? fifo_q : rate_out);
  end

  // Rate words buffered, but the FIFO drains every cycle, so it holds at most one word.
  rfm_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_in  (core_clk_in),
    .rst_in       (rst_in),
    .wr_data_in   (rate_out),
    .wr_valid_in  (sample_tick_in && fifo_rdy),
    .wr_ready_out (fifo_rdy),
    .rd_data_out  (fifo_q),
    .rd_valid_out (fifo_val),
    .rd_ready_in  (1'b1)
  );
  // The reader drains every cycle, so the head never goes stale.
  // A word waits at most one cycle; otherwise capture sees rate_out.

  // Severe excursion must always invalidate status.
  property p_severe;
    @(posedge core_clk_in) disable iff (rst_in)
      (dev > ST_SEVERE_TOL) |=> (sensor_status_field_out == STATUS_INVALID);
  endproperty
  a_severe: assert property (p_severe) else $error("severe not invalid");

  property p_mild;
    @(posedge core_clk_in) disable iff (rst_in)
      (dev > ST_MILD_TOL && dev <= ST_SEVERE_TOL) |=>
        (self_test_fault_flag_out && sensor_status_field_out == STATUS_VALID);
  endproperty
  a_mild: assert property (p_mild) else $error("mild wrong");

  property p_alt;
    @(posedge core_clk_in) disable iff (rst_in)
      sample_tick_in |=> (st_drive_out != $past(st_drive_out));
  endproperty
  a_alt: assert property (p_alt) else $error("stimulus stuck");

  property p_rate;
    @(posedge core_clk_in) disable iff (rst_in)
      sample_tick_in |=> (rate_out == 16'($past(next_sum2) >>> 12));
  endproperty
  a_rate: assert property (p_rate) else $error("rate not updated");

  property p_stmem;
    @(posedge core_clk_in) disable iff (rst_in)
      ##1 (self_test_memory_out == $past(st_mag));
  endproperty
  a_stmem: assert property (p_stmem) else $error("st memory stale");

  property p_thr;
    @(posedge core_clk_in) ST_SEVERE_TOL > ST_MILD_TOL;
  endproperty
  a_thr: assert property (p_thr) else $error("thresholds order");

  property p_cap;
    @(posedge core_clk_in) disable iff (rst_in)
      (cs_prev && !cs_sync[1]) |=> (held == $past(capture));
  endproperty
  a_cap: assert property (p_cap) else $error("capture missed");

  property p_hidx;
    @(posedge core_clk_in) disable iff (rst_in)
      sample_tick_in |=> (hidx == 6'($past(hidx) + 1));
  endproperty
  a_hidx: assert property (p_hidx) else $error("window index");

  // A small excursion must leave the fault flag clear.
  property p_fault_clear;
    @(posedge core_clk_in) disable iff (rst_in)
      (dev <= ST_MILD_TOL) |=> !self_test_fault_flag_out;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault set");

  // Anything short of severe keeps the status valid.
  property p_valid;
    @(posedge core_clk_in) disable iff (rst_in)
      (dev <= ST_SEVERE_TOL) |=> (sensor_status_field_out == STATUS_VALID);
  endproperty
  a_valid: assert property (p_valid) else $error("status not valid");

  // The word held at chip select reaches the shifter on completion.
  property p_shift;
    @(posedge core_clk_in) disable iff (rst_in)
      (!done_prev && done_sync[1]) |=> (shift_word_out == $past(held));
  endproperty
  a_shift: assert property (p_shift) else $error("shifter not loaded");

  // The self-test group counter advances by one on each sample.
  property p_stcnt;
    @(posedge core_clk_in) disable iff (rst_in)
      sample_tick_in |=> (st_cnt == 4'($past(st_cnt) + 1));
  endproperty
  a_stcnt: assert property (p_stcnt) else $error("group count");

  // Between ticks the self-test filter output must not move.
  property p_sty_hold;
    @(posedge core_clk_in) disable iff (rst_in)
      !sample_tick_in |=> $stable(st_y);
  endproperty
  a_sty_hold: assert property (p_sty_hold) else $error("st moved");

  // Between ticks the rate register keeps its value.
  property p_rate_hold;
    @(posedge core_clk_in) disable iff (rst_in)
      !sample_tick_in |=> $stable(rate_out);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate moved");

  // The stimulus only changes polarity on a sample.
  property p_drive_hold;
    @(posedge core_clk_in) disable iff (rst_in)
      !sample_tick_in |=> $stable(st_drive_out);
  endproperty
  a_drive_hold: assert property (p_drive_hold) else $error("drive moved");
endmodule : rfm_monitor

// [rfm_pkg.sv]
// Functional notes
// - Rate path: two cascaded 64-sample running sums, once per resonator sample.
// - Self-test path: recursive filter 1/(64-63z^-1), updated every 16 samples.
// - Self-test difference filtered to f/8000 and compared continuously.
// - Mild self-test excursion sets fault flag, status stays 0b01.
// - Severe self-test excursion sets fault flag, status forced to 0b00.
// - Self-test result readable by host at register 0x04.
// - Stimulus alternates equal positive and negative deflections, nets to zero.
// - Self-test stimulation runs continuously with no host request.
// - Self-test response shares the rate processing chain before separation.
// - Calibration offset and gain applied to samples; self-test correction added in the self-test filter.
// - Rate filter group delay about 4 ms to within 10 percent.
// - Output data captured at chip select, loaded into shifter afterwards.
// - Rate counts rise for clockwise rotation, two's complement.
package rfm_pkg;
  localparam int          SAMPLE_W       = 16;
  localparam int          ACC_W          = 28;
  localparam int          TAPS           = 64;
  localparam int          ST_DIV         = 16;
  localparam int          ST_GAIN        = 64;
  localparam int          ST_FEEDBACK    = 63;
  localparam int          ST_BW_DIV      = 8000;
  localparam logic [8:0]  ADDR_SELF_TEST = 9'h004;
  localparam logic [8:0]  ADDR_RATE      = 9'h000;
  localparam logic [15:0] ST_NOMINAL     = 16'h0400;
  localparam logic [15:0] ST_MILD_TOL    = 16'h0100;
  localparam logic [15:0] ST_SEVERE_TOL  = 16'h0200;
  localparam logic [1:0]  STATUS_VALID   = 2'b01;
  localparam logic [1:0]  STATUS_INVALID = 2'b00;
  localparam int          FIFO_DEPTH     = 8;
  localparam real         GROUP_DELAY_MS = 4.0;
  localparam real         SAMPLE_KHZ     = 15.2;
endpackage : rfm_pkg

// [rfm_tb_top.sv]
`timescale 1ns/1ps
module rfm_tb_top import rfm_pkg::*;;
  logic               clk   = 1'b0;
  logic               rst   = 1'b1;
  logic               tick  = 1'b0;
  logic signed [15:0] demod = 16'sh0000;
  logic               cs_n, done, st_drive, fault;
  logic [8:0]         addr;
  logic signed [15:0] rate;
  logic [15:0]        st_mem, shift_word, word;
  logic [1:0]         status;
  int                 fails       = 0;
  int                 checks_done = 0;

  // The clock runs at 25 MHz.
  always #20 clk = ~clk;

  // Calibration is held at unity, so the expected values stay exact.
  rfm_monitor u_rfm_monitor (
    .core_clk_in(clk), .rst_in(rst), .sample_tick_in(tick),
    .demod_in(demod), .cal_offset_in(16'sh0000), .cal_gain_in(16'h1000),
    .cal_st_in(16'sh0000), .cs_n_in(cs_n), .cmd_done_in(done),
    .cmd_addr_in(addr), .st_drive_out(st_drive), .rate_out(rate),
    .self_test_memory_out(st_mem), .self_test_fault_flag_out(fault),
    .sensor_status_field_out(status), .shift_word_out(shift_word));
  rfm_host u_rfm_host (.core_clk_in(clk), .shift_word_in(shift_word),
    .cs_n_out(cs_n), .done_out(done), .addr_out(addr));

  // This task compares one value and counts a mismatch if it differs.
  task automatic check(input string name, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // This task prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // Each sample follows the stimulus polarity, as the sense structure does.
  // Ticks are two cycles apart, so the tick spacing is always legal.
  task automatic run_ticks(input int n, input logic signed [15:0] r, a);
    repeat (n) begin
      @(negedge clk);
      demod = st_drive ? r + a : r - a;
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
    end
  endtask : run_ticks

  // This test checks the reset values while reset still holds them.
  // The empty self-test filter reads as a fault once reset is released.
  task automatic t_reset();
    repeat (3) @(negedge clk);
    check("rate", rate, 16'h0000);
    check("fault", {15'h0000, fault}, 16'h0000);
    check("status", {14'h0000, status}, 16'h0001);
    check("self_test_memory", st_mem, 16'h0000);
    rst = 1'b0;
    @(negedge clk);
    $display("Test reset done");
  endtask : t_reset

  // A steady rate with the stimulus on must come out as that rate exactly.
  task automatic t_rate(input logic signed [15:0] r);
    logic d0;
    d0 = st_drive;
    run_ticks(1, r, 16'sh0200);
    check("st_drive", {15'h0000, st_drive}, {15'h0000, ~d0});
    run_ticks(140, r, 16'sh0200);
    check("rate", rate, r);
    u_rfm_host.read_word(ADDR_RATE, word);
    check("rate_word", word, r);
    $display("Test rate %h done", r);
  endtask : t_rate

  // The filter settles to twice the amplitude; truncation leaves it a bit low.
  task automatic t_selftest(input logic [15:0] a, input logic f,
                            input logic [1:0] s);
    logic [15:0] d;
    d = a << 1;
    run_ticks(7000, 16'sh0000, a);
    check("fault", {15'h0000, fault}, {15'h0000, f});
    check("status", {14'h0000, status}, {14'h0000, s});
    check("st_mem", {15'h0000, st_mem > d - 16'h0050 && st_mem <= d},
          16'h0001);
    u_rfm_host.read_word(ADDR_SELF_TEST, word);
    check("st_word", {15'h0000, word > d - 16'h0050 && word <= d},
          16'h0001);
    $display("Test self-test %h done", a);
  endtask : t_selftest

  // The main sequence: ends in conclude.
  initial begin
    t_reset();
    t_rate(16'sh0123);
    t_rate(-16'sh0123);
    t_selftest(16'h0200, 1'b0, STATUS_VALID);
    t_selftest(16'h02c0, 1'b1, STATUS_VALID);
    t_selftest(16'h0380, 1'b1, STATUS_INVALID);
    conclude();
  end

  // The watchdog cuts a hang short and counts it as a mismatch.
  initial begin
    #4000000;
    fails++;
    conclude();
  end
endmodule : rfm_tb_top
